/* File: floppy_regs_params.svh */
// Function
// R01: Mode input picks compatible or enhanced layout
// R02: Compatible read drives only bits 1..0
// R03: Tape select: none, drive 1, 2, 3
// R04: Enhanced bits 7..6 return media sense pins
// R05: Enhanced bits 5..4 always read zero
// R06: Map field swaps logical drives onto pins
// R07: Status register readable at any time
// R08: Status reads 00 during init, then 80
// R09: Ready status within 2.5 us of reset
// R10: Host request clears on transfer, resets ready
// R11: Non-DMA execution: host request mirrors interrupt
// R12: Bit 6 gives transfer direction
// R13: Bit 5 shows non-DMA execution phase
// R14: Command busy from first byte to end
// R15: Per-drive seek busy set/clear by commands
// R16: Rate follows latest rate or config write
// R17: Hardware reset loads 02, soft reset keeps
// R18: Bit 7 write triggers self-clearing soft reset
// R19: Bit 6 write enters powerdown until reset
// R20: Shift field selects precompensation delay
// R21: Precompensation starts at configurable track
// R22: Rate field selects rate and default shift
// R23: Logical drive selects decoded from output control
// R24: Rate register bit 5 held at zero
`ifndef FLOPPY_REGS_PARAMS_SVH
`define FLOPPY_REGS_PARAMS_SVH
`define FR_ADDR_TAPE      3'h3
`define FR_ADDR_STATUS    3'h4
`define FR_RATE_RST       8'h02
`define FR_BIT_SOFT_RST   7
`define FR_BIT_PDOWN      6
`define FR_SHIFT_HI       4
`define FR_SHIFT_LO       2
`define FR_RATE_HI        1
`define FR_RATE_LO        0
`define FR_MAP_HI         3
`define FR_MAP_LO         2
`define FR_OE_COMPAT      8'h03
`define FR_OE_ALL         8'hff
`define FR_CLK_PERIOD_NS  25
`define FR_READY_MAX_NS   2500
`define FR_READY_CYCLES   (`FR_READY_MAX_NS / `FR_CLK_PERIOD_NS)
`define FR_PS_41_7        18'h0a2e4
`define FR_PS_83_3        18'h14564
`define FR_PS_125_0       18'h1e848
`define FR_PS_66_7        18'h1048c
`define FR_PS_208_3       18'h32dac
`define FR_PS_250_0       18'h3d090
`define FR_PS_ZERO        18'h00000
`endif

/* File: floppy_regs_pkg.sv */
package floppy_regs_pkg;
  // Controller life cycle
  typedef enum logic [1:0] {ST_INIT, ST_READY, ST_POWERDOWN} ctrl_state_t;

  // Whole register state of the top block
  typedef struct packed {
    ctrl_state_t st;         // Life cycle state
    logic [6:0]  init_cnt;   // Init delay counter
    logic [1:0]  tape_sel;   // Tape drive select field
    logic [1:0]  map_sel;    // Drive map select field
    logic [2:0]  shift_sel;  // Write shift select field
    logic [1:0]  rate_sel;   // Active rate select
    logic        pd_flag;    // Manual powerdown bit
    logic        soft_pulse; // Self-clearing soft reset
    logic        req_latch;  // Ready for next byte
    logic        cmd_busy;   // Command in progress
    logic [3:0]  seek_busy;  // Per-drive seek busy
    logic [7:0]  rdata;      // Read data register
    logic [7:0]  rdata_oe;   // Per-bit drive enable
  } regs_t;
endpackage

/* File: floppy_regs_if.sv */
interface floppy_regs_if;
  logic [1:0]  dsel;        // Logical drive select
  logic [3:0]  motor_en;    // Logical motor enables
  logic        map_en;      // Mapping enabled
  logic [1:0]  map_sel;     // Map field
  logic [1:0]  motor_n;     // Physical motor pins, active low
  logic [1:0]  drive_n;     // Physical drive pins, active low
  logic [1:0]  rate;        // Active rate select
  logic [2:0]  shift;       // Write shift select
  logic [7:0]  cur_track;   // Track being written
  logic [7:0]  start_track; // First precompensated track
  logic [17:0] precomp_ps;  // Shift amount in ps
  logic        fm_ok;       // FM legal at this rate
  logic        precomp_on;  // Precompensation active

  modport owner  (output dsel, motor_en, map_en, map_sel, rate, shift, cur_track,
                  start_track, input motor_n, drive_n, precomp_ps, fm_ok, precomp_on);
  modport mapper (input dsel, motor_en, map_en, map_sel, output motor_n, drive_n);
  modport shaper (input rate, shift, cur_track, start_track,
                  output precomp_ps, fm_ok, precomp_on);
endinterface

/* File: drive_pin_mapper.sv */
module drive_pin_mapper
  import floppy_regs_pkg::*;
(
  floppy_regs_if.mapper bus
);
  logic [3:0] log_dr;  // One-hot logical drive selects
  logic [1:0] pos1;    // Logical drive on pin pair 1
  logic [1:0] pos0;    // Logical drive on pin pair 0

  // Binary select means only one drive is active at once
  always_comb
  begin
    log_dr = 4'h0;
    log_dr[bus.dsel] = 1'b1; // R23
    pos1 = 2'h1;
    pos0 = 2'h0;
    if (bus.map_en && bus.map_sel == 2'h1)
    begin
      pos1 = 2'h0; // R06
      pos0 = 2'h1;
    end
    else if (bus.map_en && bus.map_sel[1])
    begin
      pos0 = bus.map_sel; // R06
    end
    bus.motor_n = ~{bus.motor_en[pos1], bus.motor_en[pos0]};
    bus.drive_n = ~{log_dr[pos1], log_dr[pos0]};
  end
endmodule // drive_pin_mapper

/* File: precomp_selector.sv */
`include "floppy_regs_params.svh"
module precomp_selector
  import floppy_regs_pkg::*;
(
  floppy_regs_if.shaper bus
);
  // Shift amount from field; zero code takes the rate default
  always_comb
  begin
    case (bus.shift) // R20
      3'h1: bus.precomp_ps = `FR_PS_41_7;
      3'h2: bus.precomp_ps = `FR_PS_83_3;
      3'h3: bus.precomp_ps = `FR_PS_125_0;
      3'h4: bus.precomp_ps = `FR_PS_66_7;
      3'h5: bus.precomp_ps = `FR_PS_208_3;
      3'h6: bus.precomp_ps = `FR_PS_250_0;
      3'h7: bus.precomp_ps = `FR_PS_ZERO;
      default: bus.precomp_ps = (bus.rate == 2'h3) ? `FR_PS_41_7 : `FR_PS_125_0; // R22
    endcase
    bus.fm_ok = (bus.rate != 2'h3); // R22
    bus.precomp_on = (bus.cur_track >= bus.start_track); // R21
  end
endmodule // precomp_selector

/* File: floppy_ctrl_status_rate_regs.sv */
`include "floppy_regs_params.svh"
module floppy_ctrl_status_rate_regs
  import floppy_regs_pkg::*;
(
  input  wire logic        ref_clk_i,             // 40 MHz clock
  input  wire logic        soft_reset_self_clear_i,                // Hardware reset
  input  wire logic [2:0]  addr_i,                // Register address
  input  wire logic        rd_i,                  // Read strobe
  input  wire logic        wr_i,                  // Write strobe
  input  wire logic [7:0]  wdata_i,               // Write data
  output logic      [7:0]  rdata_o,               // Read data
  output logic      [7:0]  rdata_oe_o,            // Per-bit read drive enable
  input  wire logic        enhanced_mode_i,       // Layout select from config
  input  wire logic        drive_map_en_i,        // Drive mapping enable
  input  wire logic        media_sense_hi_i,      // Media sense pin 1
  input  wire logic        media_sense_lo_i,      // Media sense pin 0
  input  wire logic [1:0]  ctl_drive_sel_i,       // Output control drive select
  input  wire logic [3:0]  ctl_motor_en_i,        // Output control motor enables
  input  wire logic        ctl_reset_n_i,         // Output control reset bit
  input  wire logic        cfg_wr_i,              // Config rate register write
  input  wire logic [1:0]  cfg_rate_i,            // Config rate value
  input  wire logic        engine_ready_i,        // Engine can move a byte
  input  wire logic        data_xfer_i,           // Data byte moved, pulse
  input  wire logic        xfer_dir_read_i,       // Host should read data
  input  wire logic        exec_nondma_i,         // Non-DMA execution phase
  input  wire logic        irq_i,                 // Controller interrupt line
  input  wire logic        cmd_first_byte_i,      // First command byte, pulse
  input  wire logic        cmd_last_byte_i,       // Last command byte, pulse
  input  wire logic        cmd_has_result_i,      // Command has result phase
  input  wire logic        result_last_read_i,    // Last result byte read, pulse
  input  wire logic        seek_done_i,           // Seek/recal accepted, pulse
  input  wire logic [1:0]  seek_drive_i,          // Drive of that seek
  input  wire logic        sense_first_read_i,    // Sense-int first result, pulse
  input  wire logic [1:0]  sense_drive_i,         // Drive of that sense
  input  wire logic [7:0]  cur_track_i,           // Track being written
  input  wire logic [7:0]  precomp_start_track_i, // Configured start track
  output logic [1:0]       tape_drive_sel_o,      // Tape drive assignment
  output logic [1:0]       rate_select_o,         // Active rate select
  output logic [2:0]       write_shift_select_o,  // Shift select field
  output logic [17:0]      precomp_ps_o,          // Shift amount in ps
  output logic             fm_legal_o,            // FM allowed at this rate
  output logic             precomp_active_o,      // Shift applies now
  output logic             core_reset_o,          // Core held in reset
  output logic             powerdown_o,           // Manual powerdown active
  output logic             motor_out_pin_1_n_o,   // Physical motor 1, active low
  output logic             motor_out_pin_0_n_o,   // Physical motor 0, active low
  output logic             drive_out_pin_1_n_o,   // Physical drive 1, active low
  output logic             drive_out_pin_0_n_o    // Physical drive 0, active low
);
  regs_t        s;          // Registered state
  regs_t        next_s;     // Next state
  logic         soft_rst;   // Any software reset source
  logic         tape_wr;    // Tape/media register write
  logic         rate_wr;    // Rate/power register write
  logic         pd_write;   // Write that enters powerdown
  logic         host_req;   // Host request bit value
  logic [7:0]   status_val; // Main status value

  floppy_regs_if link ();

  // Sub-blocks see the registered map, rate and shift fields; select, motor, map enable and tracks are direct inputs
  assign link.dsel        = ctl_drive_sel_i;
  assign link.motor_en    = ctl_motor_en_i;
  assign link.map_en      = drive_map_en_i;
  assign link.map_sel     = s.map_sel;
  assign link.rate        = s.rate_sel;
  assign link.shift       = s.shift_sel;
  assign link.cur_track   = cur_track_i;
  assign link.start_track = precomp_start_track_i;

  drive_pin_mapper u_mapper (
    .bus (link.mapper)
  );

  precomp_selector u_precomp (
    .bus (link.shaper)
  );

  // Output control reset bit is a level; rate register bit a pulse
  assign soft_rst = s.soft_pulse | ~ctl_reset_n_i; // R18
  assign tape_wr  = wr_i && addr_i == `FR_ADDR_TAPE;
  assign rate_wr  = wr_i && addr_i == `FR_ADDR_STATUS;
  assign pd_write = rate_wr && wdata_i[`FR_BIT_PDOWN];

  // Non-DMA execution shows the interrupt line instead of the latch
  assign host_req = exec_nondma_i ? irq_i : s.req_latch; // R11

  // Status is all zero until init completes
  always_comb
  begin
    if (s.st == ST_READY)
    begin
      status_val = {host_req, xfer_dir_read_i, exec_nondma_i, s.cmd_busy, s.seek_busy}; // R12 R13
    end
    else
    begin
      status_val = 8'h00; // R08
    end
  end

  // Next-state logic for the whole block
  always_comb
  begin
    next_s = s;
    next_s.soft_pulse = 1'b0; // R18
    case (s.st)
      ST_INIT:
      begin
        // Fixed delay of 100 cycles, exactly the ready deadline
        next_s.init_cnt = s.init_cnt + 7'h01;
        if (s.init_cnt == 7'(`FR_READY_CYCLES - 1))
        begin
          next_s.st = ST_READY; // R09
          next_s.init_cnt = 7'h00;
          // Request latched on the same edge, else 80 shows one cycle late
          next_s.req_latch = engine_ready_i; // R08
        end
      end
      ST_READY:
      begin
        // Clear on a transfer wins so the host must re-poll
        next_s.req_latch = data_xfer_i ? 1'b0 : engine_ready_i; // R10
        // Busy clears first, then a new command may set it
        if (result_last_read_i || (cmd_last_byte_i && !cmd_has_result_i))
        begin
          next_s.cmd_busy = 1'b0; // R14
        end
        if (cmd_first_byte_i && !(cmd_last_byte_i && !cmd_has_result_i))
        begin
          next_s.cmd_busy = 1'b1; // R14
        end
        // Seek set wins over a sense clear on the same drive
        if (sense_first_read_i)
        begin
          next_s.seek_busy[sense_drive_i] = 1'b0; // R15
        end
        if (seek_done_i)
        begin
          next_s.seek_busy[seek_drive_i] = 1'b1; // R15
        end
      end
      ST_POWERDOWN:
      begin
        // Only a reset leaves this state
        next_s.st = ST_POWERDOWN; // R19
      end
      default:
      begin
        next_s.st = ST_INIT;
      end
    endcase

    // Tape/media register write; map field exists only in enhanced layout
    if (tape_wr)
    begin
      next_s.tape_sel = wdata_i[1:0]; // R03
      if (enhanced_mode_i)
      begin
        next_s.map_sel = wdata_i[`FR_MAP_HI:`FR_MAP_LO]; // R06
      end
    end

    // Config register rate write; a same-cycle rate write below wins
    if (cfg_wr_i)
    begin
      next_s.rate_sel = cfg_rate_i; // R16
    end

    // Rate/power register write; bit 5 is never stored
    if (rate_wr)
    begin
      next_s.rate_sel = wdata_i[`FR_RATE_HI:`FR_RATE_LO]; // R16
      next_s.shift_sel = wdata_i[`FR_SHIFT_HI:`FR_SHIFT_LO]; // R20 R24
      next_s.soft_pulse = wdata_i[`FR_BIT_SOFT_RST]; // R18
    end

    // Powerdown aborts everything at once
    if (pd_write)
    begin
      next_s.pd_flag = 1'b1; // R19
      next_s.st = ST_POWERDOWN;
      next_s.req_latch = 1'b0;
      next_s.cmd_busy = 1'b0;
      next_s.seek_busy = 4'h0;
    end

    // Soft reset restarts init but keeps rate and shift fields
    if (soft_rst)
    begin
      next_s.st = ST_INIT; // R08 R17
      next_s.init_cnt = 7'h00;
      next_s.pd_flag = 1'b0; // R19
      next_s.req_latch = 1'b0;
      next_s.cmd_busy = 1'b0;
      next_s.seek_busy = 4'h0;
    end

    // Registered read path; status is served with no wait
    next_s.rdata_oe = 8'h00;
    if (rd_i && addr_i == `FR_ADDR_TAPE)
    begin
      if (enhanced_mode_i) // R01
      begin
        next_s.rdata = {media_sense_hi_i, media_sense_lo_i, 2'b00, s.map_sel, s.tape_sel}; // R04 R05
        next_s.rdata_oe = `FR_OE_ALL;
      end
      else
      begin
        next_s.rdata = {6'h00, s.tape_sel};
        next_s.rdata_oe = `FR_OE_COMPAT; // R02
      end
    end
    else if (rd_i && addr_i == `FR_ADDR_STATUS)
    begin
      next_s.rdata = status_val; // R07
      next_s.rdata_oe = `FR_OE_ALL;
    end
  end

  // State register; hardware reset loads the documented defaults
  always_ff @(posedge ref_clk_i)
  begin
    if (soft_reset_self_clear_i)
    begin
      s <= '0;
      s.st <= ST_INIT;
      s.rate_sel <= 2'(`FR_RATE_RST); // R17
      s.shift_sel <= 3'h0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs
  assign rdata_o              = s.rdata;
  assign rdata_oe_o           = s.rdata_oe;
  assign tape_drive_sel_o     = s.tape_sel;
  assign rate_select_o        = s.rate_sel;
  assign write_shift_select_o = s.shift_sel;
  assign precomp_ps_o         = link.precomp_ps;
  assign fm_legal_o           = link.fm_ok;
  assign precomp_active_o     = link.precomp_on;
  assign core_reset_o         = soft_rst | (s.st == ST_POWERDOWN);
  assign powerdown_o          = s.pd_flag;
  assign motor_out_pin_1_n_o  = link.motor_n[1];
  assign motor_out_pin_0_n_o  = link.motor_n[0];
  assign drive_out_pin_1_n_o  = link.drive_n[1];
  assign drive_out_pin_0_n_o  = link.drive_n[0];

  // Checks
  chk_init_reads_zero: assert property (@(posedge ref_clk_i) disable iff (soft_reset_self_clear_i) // R08
    (rd_i && addr_i == `FR_ADDR_STATUS && s.st == ST_INIT) |=> rdata_o == 8'h00)
    else $error("status not zero during init");

  chk_ready_deadline: assert property (@(posedge ref_clk_i) disable iff (soft_reset_self_clear_i) // R09
    $fell(soft_rst) && !pd_write |-> ##[1:100] (s.st != ST_INIT))
    else $error("ready status too late");

  chk_compat_hiz: assert property (@(posedge ref_clk_i) disable iff (soft_reset_self_clear_i) // R02
    (rd_i && addr_i == `FR_ADDR_TAPE && !enhanced_mode_i) |=> rdata_oe_o == 8'h03)
    else $error("compatible read drives upper bits");

  chk_media_sense: assert property (@(posedge ref_clk_i) disable iff (soft_reset_self_clear_i) // R04
    (rd_i && addr_i == `FR_ADDR_TAPE && enhanced_mode_i) |=>
      rdata_o[5:4] == 2'b00 && rdata_o[7] == $past(media_sense_hi_i) &&
      rdata_o[6] == $past(media_sense_lo_i))
    else $error("enhanced read bits wrong");

  chk_request_clear: assert property (@(posedge ref_clk_i) disable iff (soft_reset_self_clear_i) // R10
    (data_xfer_i && s.st == ST_READY && !soft_rst && !pd_write) ##1 !exec_nondma_i
      |-> !status_val[7])
    else $error("host request not cleared after transfer");

  chk_irq_mirror: assert property (@(posedge ref_clk_i) disable iff (soft_reset_self_clear_i) // R11
    (rd_i && addr_i == `FR_ADDR_STATUS && exec_nondma_i && s.st == ST_READY) |=>
      rdata_o[7] == $past(irq_i))
    else $error("host request does not follow interrupt");

  chk_seek_set: assert property (@(posedge ref_clk_i) disable iff (soft_reset_self_clear_i) // R15
    (seek_done_i && s.st == ST_READY && !soft_rst && !pd_write) |=>
      s.seek_busy[$past(seek_drive_i)])
    else $error("seek busy not set");

  chk_soft_self_clear: assert property (@(posedge ref_clk_i) disable iff (soft_reset_self_clear_i) // R18
    (rate_wr && wdata_i[7]) |=> s.soft_pulse ##1 (!s.soft_pulse && s.st == ST_INIT))
    else $error("soft reset bit not self clearing");

  chk_pd_hold: assert property (@(posedge ref_clk_i) disable iff (soft_reset_self_clear_i) // R19
    (s.st == ST_POWERDOWN && !soft_rst) |=> s.st == ST_POWERDOWN && core_reset_o)
    else $error("powerdown left without reset");

  chk_rate_latest: assert property (@(posedge ref_clk_i) disable iff (soft_reset_self_clear_i) // R16
    (cfg_wr_i && !rate_wr) |=> rate_select_o == $past(cfg_rate_i))
    else $error("rate not from latest write");

  cov_ready: cover property (@(posedge ref_clk_i) disable iff (soft_reset_self_clear_i)
    s.st == ST_INIT ##1 s.st == ST_READY);
  cov_powerdown: cover property (@(posedge ref_clk_i) disable iff (soft_reset_self_clear_i)
    pd_write ##1 s.st == ST_POWERDOWN);
  cov_seek_cycle: cover property (@(posedge ref_clk_i) disable iff (soft_reset_self_clear_i)
    seek_done_i ##[1:20] sense_first_read_i);
endmodule // floppy_ctrl_status_rate_regs

/* File: host_bus_model.sv */
module host_bus_model
(
  input  wire logic       ref_clk_i,  // Bus clock
  input  wire logic [7:0] rdata_i,    // Read data from the block
  input  wire logic [7:0] rdata_oe_i, // Read drive enables
  output logic      [2:0] addr_o,     // Register address
  output logic            rd_o,       // Read strobe
  output logic            wr_o,       // Write strobe
  output logic      [7:0] wdata_o     // Write data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus from time zero
  initial
  begin
    addr_o  = 3'h0;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    wdata_o = 8'h00;
  end

  // One-cycle write strobe launched on the falling edge
  task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge ref_clk_i);
    wr_o    = 1'b0;
    wdata_o = ~d; // Released bus never shows the old byte
  endtask

  // Answer lands on the taking edge and is read half a cycle later; enables stand one cycle
  task automatic bus_read(input logic [2:0] a, output logic [7:0] d, output logic [7:0] oe);
    @(negedge ref_clk_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge ref_clk_i);
    rd_o = 1'b0;
    d    = rdata_i;
    oe   = rdata_oe_i;
  endtask
endmodule // host_bus_model

/* File: floppy_ctrl_status_rate_regs_tb_top.sv */
module floppy_ctrl_status_rate_regs_tb_top;
  import floppy_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) \
    begin \
      n_errors++; \
      $display("BAD %s exp %h got %h", nm, ex, got); \
    end \
  end

  logic        ref_clk = 1'b0;     // 40 MHz clock
  logic        hw_rst = 1'b1;      // Hardware reset
  wire  [2:0]  addr;               // Host bus from the model
  wire         rd, wr;             // Host strobes
  wire  [7:0]  wdata, rdata, rdata_oe;
  logic        enh = 1'b0;         // Layout select
  logic        map_en = 1'b0;      // Mapping enable
  logic [1:0]  ms = 2'h0;          // Media sense pins
  logic [1:0]  dsel = 2'h0;        // Logical drive select
  logic [3:0]  motor = 4'h0;       // Logical motors
  logic        ctl_rst_n = 1'b1;   // Output control reset bit
  logic [1:0]  cfg_rate = 2'h0;    // Config rate value
  logic        rdy = 1'b1;         // Engine ready
  logic        dir = 1'b0, nd = 1'b0, irq = 1'b0, has_res = 1'b0;
  logic [1:0]  seek_drv = 2'h0, sense_drv = 2'h0;
  logic [7:0]  cur_trk = 8'h00, start_trk = 8'h00;
  logic [6:0]  ev = 7'h00;         // Engine and config write pulses, one bit each
  wire  [1:0]  tape_sel, rate_sel; // Observed fields
  wire  [2:0]  shift_sel;
  wire  [17:0] ps;                 // Shift amount in ps
  wire         fm_ok, pc_on, core_rst, pd;
  wire  [3:0]  pins;               // Motor 1, motor 0, drive 1, drive 0
  integer      seed = 41419;       // Fixed seed keeps runs repeatable
  int          n_errors = 0, n_checks = 0, i;
  logic [31:0] w;
  logic [7:0]  e;

  floppy_ctrl_status_rate_regs i_floppy_ctrl_status_rate_regs (
    .ref_clk_i(ref_clk), .soft_reset_self_clear_i(hw_rst), .addr_i(addr), .rd_i(rd), .wr_i(wr),
    .wdata_i(wdata), .rdata_o(rdata), .rdata_oe_o(rdata_oe), .enhanced_mode_i(enh),
    .drive_map_en_i(map_en), .media_sense_hi_i(ms[1]), .media_sense_lo_i(ms[0]),
    .ctl_drive_sel_i(dsel), .ctl_motor_en_i(motor), .ctl_reset_n_i(ctl_rst_n),
    .cfg_wr_i(ev[6]), .cfg_rate_i(cfg_rate), .engine_ready_i(rdy), .data_xfer_i(ev[0]),
    .xfer_dir_read_i(dir), .exec_nondma_i(nd), .irq_i(irq), .cmd_first_byte_i(ev[1]),
    .cmd_last_byte_i(ev[2]), .cmd_has_result_i(has_res), .result_last_read_i(ev[3]),
    .seek_done_i(ev[4]), .seek_drive_i(seek_drv), .sense_first_read_i(ev[5]),
    .sense_drive_i(sense_drv), .cur_track_i(cur_trk), .precomp_start_track_i(start_trk),
    .tape_drive_sel_o(tape_sel), .rate_select_o(rate_sel), .write_shift_select_o(shift_sel),
    .precomp_ps_o(ps), .fm_legal_o(fm_ok), .precomp_active_o(pc_on), .core_reset_o(core_rst),
    .powerdown_o(pd), .motor_out_pin_1_n_o(pins[3]), .motor_out_pin_0_n_o(pins[2]),
    .drive_out_pin_1_n_o(pins[1]), .drive_out_pin_0_n_o(pins[0]));

  host_bus_model i_host_bus_model (
    .ref_clk_i(ref_clk), .rdata_i(rdata), .rdata_oe_i(rdata_oe), .addr_o(addr),
    .rd_o(rd), .wr_o(wr), .wdata_o(wdata));

  // Free-running clock
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Expected pins: position 0 carries the mapped drive, position 1 drive 1 unless swapped
  function automatic logic [3:0] exp_pins(logic en, logic [1:0] m, logic [1:0] ds,
                                          logic [3:0] mt);
    logic [1:0] p0, p1;
    p0 = en ? m : 2'h0;
    p1 = (en && m == 2'h1) ? 2'h0 : 2'h1;
    return {~mt[p1], ~mt[p0], ds != p1, ds != p0};
  endfunction

  // Expected shift in ps; code zero takes the rate default
  function automatic logic [17:0] exp_ps(logic [4:0] f);
    case (f[4:2])
      3'h0:    return (f[1:0] == 2'h3) ? 18'd41700 : 18'd125000;
      3'h1:    return 18'd41700;
      3'h2:    return 18'd83300;
      3'h3:    return 18'd125000;
      3'h4:    return 18'd66700;
      3'h5:    return 18'd208300;
      3'h6:    return 18'd250000;
      default: return 18'd0;
    endcase
  endfunction

  // Read and compare only the bits the block drives
  task automatic rchk(input logic [2:0] a, input logic [7:0] ex, input logic [7:0] exoe,
                      input string nm);
    logic [7:0] d, oe;
    i_host_bus_model.bus_read(a, d, oe);
    `CHK(nm, ex & exoe, d & oe)
    `CHK(nm, exoe, oe)
  endtask

  // One-cycle engine pulse, then a status check
  task automatic pulse_chk(input logic [6:0] m, input logic [7:0] ex);
    @(negedge ref_clk);
    ev = m;
    @(negedge ref_clk);
    ev = 7'h00;
    rchk(3'h4, ex, 8'hff, "stat_pulse");
  endtask

  // Bounded poll for the ready value
  task automatic wait_ready();
    logic [7:0] d, oe;
    int n;
    n = 0;
    d = 8'h00;
    while (d !== 8'h80 && n < 52)
    begin
      i_host_bus_model.bus_read(3'h4, d, oe);
      n++;
    end
    `CHK("ready", 8'h80, d)
    if (d !== 8'h80)
      finish_test();
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    n_errors++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    repeat (12) @(negedge ref_clk);
    hw_rst = 1'b0;
    `CHK("rst_rate", 5'h02, {shift_sel, rate_sel})
    rchk(3'h4, 8'h00, 8'hff, "stat_init");
    wait_ready();
    // Compatible layout: only the tape field is driven
    for (i = 0; i < 4; i++)
    begin
      w = $random(seed);
      i_host_bus_model.bus_write(3'h3, {w[7:2], i[1:0]});
      rchk(3'h3, {6'h00, i[1:0]}, 8'h03, "tape_compat");
      `CHK("tape_sel", i[1:0], tape_sel)
    end
    // Enhanced layout: media sense, zero bits, map field
    enh = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      w = $random(seed);
      ms = i[1:0];
      i_host_bus_model.bus_write(3'h3, w[7:0]);
      rchk(3'h3, {i[1:0], 2'b00, w[3:0]}, 8'hff, "tape_enh");
    end
    // Random mapping of logical drives onto pins
    for (i = 0; i < 40; i++)
    begin
      w = $random(seed);
      map_en = w[8];
      dsel = w[10:9];
      motor = w[14:11];
      i_host_bus_model.bus_write(3'h3, w[7:0]);
      `CHK("pins", exp_pins(map_en, w[3:2], dsel, motor), pins)
    end
    enh = 1'b0;
    rchk(3'h3, {6'h00, w[1:0]}, 8'h03, "tape_mode");
    rchk(3'h6, 8'h00, 8'h00, "unmapped");
    // Direction, non-DMA phase and interrupt mirror
    for (i = 0; i < 24; i++)
    begin
      w = $random(seed);
      {dir, nd, irq} = w[2:0];
      rchk(3'h4, {nd ? irq : 1'b1, dir, nd, 5'h00}, 8'hff, "stat_bits");
    end
    {dir, nd, irq} = 3'h0;
    ev = 7'h01;
    rchk(3'h4, 8'h00, 8'hff, "req_xfer");
    ev = 7'h00;
    rchk(3'h4, 8'h80, 8'hff, "req_back");
    // Command busy with and without result phase
    has_res = 1'b1;
    pulse_chk(7'h02, 8'h90);
    pulse_chk(7'h04, 8'h90);
    pulse_chk(7'h08, 8'h80);
    has_res = 1'b0;
    pulse_chk(7'h02, 8'h90);
    pulse_chk(7'h04, 8'h80);
    pulse_chk(7'h06, 8'h80);
    // Per-drive seek busy set, then cleared in reverse
    e = 8'h80;
    for (i = 0; i < 4; i++)
    begin
      seek_drv = i[1:0];
      e[i] = 1'b1;
      pulse_chk(7'h10, e);
    end
    for (i = 3; i >= 0; i--)
    begin
      sense_drv = i[1:0];
      e[i] = 1'b0;
      pulse_chk(7'h20, e);
    end
    // Latest of config or rate write wins
    cfg_rate = 2'h3;
    @(negedge ref_clk);
    ev = 7'h40;
    @(negedge ref_clk);
    ev = 7'h00;
    `CHK("cfg_rate", 2'h3, rate_sel)
    i_host_bus_model.bus_write(3'h4, 8'h00);
    `CHK("rpc_rate", 2'h0, rate_sel)
    // Every rate and shift code, bit 5 random
    for (i = 0; i < 32; i++)
    begin
      w = $random(seed);
      i_host_bus_model.bus_write(3'h4, {2'b00, w[0], i[4:0]});
      `CHK("rate", i[1:0], rate_sel)
      `CHK("shift", i[4:2], shift_sel)
      `CHK("ps", exp_ps(i[4:0]), ps)
      `CHK("fm", i[1:0] != 2'h3, fm_ok)
      `CHK("pd_b5", 1'b0, pd)
    end
    // Start track compare, zero and equal corners first
    for (i = 0; i < 10; i++)
    begin
      w = $random(seed);
      {cur_trk, start_trk} = (i == 0) ? 16'h0000 : (i == 1) ? {w[7:0], w[7:0]} : w[15:0];
      #1;
      `CHK("pc_on", cur_trk >= start_trk, pc_on)
    end
    // Self-clearing soft reset keeps the rate settings
    i_host_bus_model.bus_write(3'h4, 8'h8d);
    `CHK("core_rst", 1'b1, core_rst)
    @(negedge ref_clk);
    rchk(3'h4, 8'h00, 8'hff, "stat_soft");
    `CHK("rate_kept", 5'h0d, {shift_sel, rate_sel})
    wait_ready();
    `CHK("soft_reset_self_clear_clear", 1'b0, core_rst)
    // Powerdown aborts a busy command and holds until reset
    pulse_chk(7'h02, 8'h90);
    i_host_bus_model.bus_write(3'h4, 8'h40);
    `CHK("pd_on", 2'h3, {pd, core_rst})
    repeat (150) @(negedge ref_clk);
    `CHK("pd_hold", 1'b1, pd)
    rchk(3'h4, 8'h00, 8'hff, "stat_pd");
    ctl_rst_n = 1'b0;
    @(negedge ref_clk);
    ctl_rst_n = 1'b1;
    @(negedge ref_clk);
    `CHK("pd_off", 1'b0, pd)
    wait_ready();
    // Second hardware reset restores the rate register
    hw_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    hw_rst = 1'b0;
    `CHK("hw_rate", 5'h02, {shift_sel, rate_sel})
    rchk(3'h4, 8'h00, 8'hff, "stat_hw");
    finish_test();
  end
endmodule // floppy_ctrl_status_rate_regs_tb_top
